// ==== shared/cexo_regs.vh ====
// Constants for the execute-stage subset: opcodes, flag positions, resets.
// Assumes inclusion by bare name from the execute-stage files.
`ifndef CEXO_REGS_VH
`define CEXO_REGS_VH
// ----------------------------------------------------------------------------
// Operation select codes
// ----------------------------------------------------------------------------
`define CEXO_OP_NOP      3'h0
`define CEXO_OP_SLEEP    3'h1
`define CEXO_OP_RRF      3'h2
`define CEXO_OP_SUBLIT   3'h3
`define CEXO_OP_SUBFILE  3'h4
`define CEXO_OP_XORLIT   3'h5
`define CEXO_OP_XORFILE  3'h6
`define CEXO_OP_SWAP     3'h7
// ----------------------------------------------------------------------------
// Status flag positions
// ----------------------------------------------------------------------------
`define CEXO_ST_C        0
`define CEXO_ST_DC       1
`define CEXO_ST_Z        2
`define CEXO_ST_PD_N     3
`define CEXO_ST_TO_N     4
// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CEXO_RST_ACC     8'h00
`define CEXO_RST_STATUS  5'h18
`define CEXO_RST_WDOG    8'h00
`define CEXO_RST_PRESC   8'h00
`define CEXO_WDOG_CLEAR  8'h00
`endif

// ==== src/cexo_alu.v ====
// Combinational ALU for the execute-stage subset.
// Assumes operands are stable for the whole instruction cycle.
`include "cexo_regs.vh"
`default_nettype none
module cexo_alu (
  input  wire [2:0] op,
  input  wire [7:0] acc,
  input  wire [7:0] operand,
  input  wire       carry_in,
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        dc_out,
  output reg        upd_c,
  output reg        upd_dc,
  output reg        upd_z
);
  reg [8:0] diff;
  reg [4:0] ndiff;
  always @* begin
    diff      = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
    ndiff     = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    result    = 8'h00;
    carry_out = carry_in;
    dc_out    = 1'b0;
    upd_c     = 1'b0;
    upd_dc    = 1'b0;
    upd_z     = 1'b0;
    case (op)
      `CEXO_OP_RRF: begin
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
        upd_c     = 1'b1;
      end
      `CEXO_OP_SUBLIT, `CEXO_OP_SUBFILE: begin
        result    = diff[7:0];
        carry_out = diff[8];
        dc_out    = ndiff[4];
        upd_c     = 1'b1;
        upd_dc    = 1'b1;
        upd_z     = 1'b1;
      end
      `CEXO_OP_XORLIT, `CEXO_OP_XORFILE: begin
        result = acc ^ operand;
        upd_z  = 1'b1;
      end
      `CEXO_OP_SWAP: begin
        result = {operand[3:0], operand[7:4]};
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end
endmodule // cexo_alu
`default_nettype wire

// ==== src/cexo_core.v ====
// Execute stage for sleep, rotate-right, subtract, xor and swap.
// Assumes decode supplies one op per cycle with its file value already read.
//
// Behaviour
// - Sleep clears the watchdog counter and its prescaler to zero.
// - Sleep writes power-down flag low and timeout flag high, no other flags.
// - After sleep the core halts and executes nothing until wake, passed through two flops, returns it to run.
// - Rotate right moves carry into bit 7 and bit 0 into carry, only carry changes.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Literal subtract places literal minus accumulator in the accumulator, C DC Z updated.
// - Literal subtract carry is 0 when accumulator exceeds literal, digit carry is 0 when its low nibble exceeds the literal's.
// - File subtract places file minus accumulator at the destination with same flag rules.
// - Xor literal places accumulator xor literal in the accumulator, only Z changes.
// - Xor file places accumulator xor file at the destination, only Z changes.
// - Nibble swap exchanges file nibbles into the destination, no flags change.
`include "cexo_regs.vh"
`default_nettype none
module cexo_core #(
  parameter ADDR_W = 7
) (
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire              instr_valid,
  input  wire [2:0]        instr_op,
  input  wire [7:0]        literal,
  input  wire [ADDR_W-1:0] file_addr,
  input  wire [7:0]        file_data,
  input  wire              dest_sel,
  input  wire              watchdog_tick,
  input  wire              wake,
  output reg  [7:0]        acc_q,
  output reg               carry_q,
  output reg               digit_carry_flag_q,
  output reg               zero_q,
  output reg               power_down_flag_n_q,
  output reg               timeout_flag_n_q,
  output reg               file_we_q,
  output reg  [ADDR_W-1:0] file_waddr_q,
  output reg  [7:0]        file_wdata_q,
  output reg  [7:0]        watchdog_counter_q,
  output reg  [7:0]        prescaler_q,
  output reg               osc_halt_q
);
  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  localparam [1:0] ST_RUN   = 2'b01;
  localparam [1:0] ST_SLEEP = 2'b10;
  localparam [4:0] RST_FLAGS = `CEXO_RST_STATUS;
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg        wake_s1_q;
  reg        wake_s2_q;

  // --------------------------------------------------------------------------
  // ALU
  // --------------------------------------------------------------------------
  wire       lit_op;
  wire [7:0] operand;
  wire [7:0] result;
  wire       c_out;
  wire       dc_out;
  wire       upd_c;
  wire       upd_dc;
  wire       upd_z;
  wire       exec;

  assign lit_op  = (instr_op == `CEXO_OP_SUBLIT) || (instr_op == `CEXO_OP_XORLIT);
  assign operand = lit_op ? literal : file_data;
  assign exec    = instr_valid && (state_q == ST_RUN);

  cexo_alu u_alu (
    .op        (instr_op),
    .acc       (acc_q),
    .operand   (operand),
    .carry_in  (carry_q),
    .result    (result),
    .carry_out (c_out),
    .dc_out    (dc_out),
    .upd_c     (upd_c),
    .upd_dc    (upd_dc),
    .upd_z     (upd_z)
  );

  function writes_file;
    input [2:0] op;
    input       d;
    begin
      writes_file = d && ((op == `CEXO_OP_RRF) || (op == `CEXO_OP_SUBFILE) ||
                          (op == `CEXO_OP_XORFILE) || (op == `CEXO_OP_SWAP));
    end
  endfunction

  function writes_acc;
    input [2:0] op;
    input       d;
    begin
      writes_acc = (op == `CEXO_OP_SUBLIT) || (op == `CEXO_OP_XORLIT) ||
                   (!d && ((op == `CEXO_OP_RRF) || (op == `CEXO_OP_SUBFILE) ||
                           (op == `CEXO_OP_XORFILE) || (op == `CEXO_OP_SWAP)));
    end
  endfunction

  // --------------------------------------------------------------------------
  // Sleep state machine
  // --------------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (exec && instr_op == `CEXO_OP_SLEEP) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_s2_q) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_RUN;
      osc_halt_q <= 1'b0;
      wake_s1_q  <= 1'b0;
      wake_s2_q  <= 1'b0;
    end else begin
      wake_s1_q  <= wake;
      wake_s2_q  <= wake_s1_q;
      state_q    <= state_d;
      osc_halt_q <= (state_d == ST_SLEEP);
    end
  end

  // --------------------------------------------------------------------------
  // Watchdog counter and prescaler
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter_q <= `CEXO_RST_WDOG;
      prescaler_q        <= `CEXO_RST_PRESC;
    end else if (exec && instr_op == `CEXO_OP_SLEEP) begin
      watchdog_counter_q <= `CEXO_WDOG_CLEAR;
      prescaler_q        <= `CEXO_WDOG_CLEAR;
    end else if (watchdog_tick) begin
      prescaler_q <= prescaler_q + 8'h01;
      if (prescaler_q == 8'hff) begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Accumulator, flags and file write-back
  // --------------------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q               <= `CEXO_RST_ACC;
      carry_q             <= RST_FLAGS[`CEXO_ST_C];
      digit_carry_flag_q  <= RST_FLAGS[`CEXO_ST_DC];
      zero_q              <= RST_FLAGS[`CEXO_ST_Z];
      power_down_flag_n_q <= RST_FLAGS[`CEXO_ST_PD_N];
      timeout_flag_n_q    <= RST_FLAGS[`CEXO_ST_TO_N];
      file_we_q           <= 1'b0;
      file_waddr_q        <= {ADDR_W{1'b0}};
      file_wdata_q        <= 8'h00;
    end else begin
      file_we_q <= 1'b0;
      if (exec) begin
        if (instr_op == `CEXO_OP_SLEEP) begin
          power_down_flag_n_q <= 1'b0;
          timeout_flag_n_q    <= 1'b1;
        end
        if (writes_acc(instr_op, dest_sel)) begin
          acc_q <= result;
        end
        if (writes_file(instr_op, dest_sel)) begin
          file_we_q    <= 1'b1;
          file_waddr_q <= file_addr;
          file_wdata_q <= result;
        end
        if (upd_c) begin
          carry_q <= c_out;
        end
        if (upd_dc) begin
          digit_carry_flag_q <= dc_out;
        end
        if (upd_z) begin
          zero_q <= (result == 8'h00);
        end
      end
    end
  end
endmodule // cexo_core
`default_nettype wire

// ==== bench/cexo_core_properties.sv ====
// Checker for the execute-stage subset on the core's ports.
// Assumes the header constants and a bind onto cexo_core.
`include "cexo_regs.vh"
`default_nettype none
module cexo_core_properties #(
  parameter ADDR_W = 7
) (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              instr_valid,
  input wire logic [2:0]        instr_op,
  input wire logic [7:0]        literal,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic [7:0]        file_data,
  input wire logic              dest_sel,
  input wire logic [7:0]        acc_q,
  input wire logic              carry_q,
  input wire logic              digit_carry_flag_q,
  input wire logic              zero_q,
  input wire logic              power_down_flag_n_q,
  input wire logic              timeout_flag_n_q,
  input wire logic              file_we_q,
  input wire logic [ADDR_W-1:0] file_waddr_q,
  input wire logic [7:0]        watchdog_counter_q,
  input wire logic [7:0]        prescaler_q,
  input wire logic              osc_halt_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Helpers
  // ----
  wire go = instr_valid && !osc_halt_q;
  wire fop = instr_op == `CEXO_OP_RRF || instr_op == `CEXO_OP_SUBFILE || instr_op == `CEXO_OP_XORFILE
             || instr_op == `CEXO_OP_SWAP;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // Properties
  // ----
  chk_sleep_wdog: assert property (go && instr_op == `CEXO_OP_SLEEP |=>
    watchdog_counter_q == 8'h00 && prescaler_q == 8'h00) else $error("watchdog not cleared by sleep");
  chk_sleep_flags: assert property (go && instr_op == `CEXO_OP_SLEEP |=>
    !power_down_flag_n_q && timeout_flag_n_q && $stable({carry_q, digit_carry_flag_q, zero_q}))
    else $error("sleep status flags wrong");
  chk_sleep_halt: assert property (go && instr_op == `CEXO_OP_SLEEP |=> osc_halt_q [*2])
    else $error("core did not halt");
  chk_halt_ignore: assert property (osc_halt_q |=> $stable(acc_q) && !file_we_q)
    else $error("instruction ran while asleep");
  chk_rrf_carry: assert property (go && instr_op == `CEXO_OP_RRF |=> carry_q == $past(file_data[0]))
    else $error("rotate carry wrong");
  chk_dest_file: assert property (go && fop && dest_sel |=>
    file_we_q && file_waddr_q == $past(file_addr) && $stable(acc_q)) else $error("file destination wrong");
  chk_sub_carry: assert property (go && instr_op == `CEXO_OP_SUBLIT |=>
    carry_q == ($past(acc_q) <= $past(literal))) else $error("subtract carry wrong");
  chk_xor_lit: assert property (go && instr_op == `CEXO_OP_XORLIT |=>
    acc_q == ($past(acc_q) ^ $past(literal)) && $stable(carry_q)) else $error("xor literal wrong");
  chk_zero_flag: assert property (go && instr_op == `CEXO_OP_XORLIT |=> zero_q == (acc_q == 8'h00))
    else $error("zero flag wrong");
  chk_swap_flags: assert property (go && instr_op == `CEXO_OP_SWAP |=>
    $stable({carry_q, digit_carry_flag_q, zero_q})) else $error("swap touched flags");
  cov_sleep: cover property (go && instr_op == `CEXO_OP_SLEEP);
  cov_sub_borrow: cover property (go && instr_op == `CEXO_OP_SUBLIT ##1 !carry_q);
  cov_file_write: cover property (go && fop && dest_sel);
endmodule // cexo_core_properties
bind cexo_core cexo_core_properties #(.ADDR_W(ADDR_W)) u_chk (.sys_clk, .rst_n, .instr_valid, .instr_op,
  .literal, .file_addr, .file_data, .dest_sel, .acc_q, .carry_q, .digit_carry_flag_q, .zero_q,
  .power_down_flag_n_q, .timeout_flag_n_q, .file_we_q, .file_waddr_q, .watchdog_counter_q, .prescaler_q,
  .osc_halt_q);
`default_nettype wire

// ==== bench/cexo_core_test.sv ====
// Self-checking bench for the execute-stage subset.
// Assumes cexo_core and its checker are compiled first.
`include "cexo_regs.vh"
`default_nettype none
module cexo_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk, rst_n, instr_valid, dest_sel, watchdog_tick, wake, m_c, m_dc, m_z, m_pd;
  logic [2:0] instr_op;
  logic [7:0] literal, file_data, m_acc;
  logic [6:0] file_addr;
  wire  [7:0] acc_q, file_wdata_q, watchdog_counter_q, prescaler_q;
  wire  [6:0] file_waddr_q;
  wire        carry_q, digit_carry_flag_q, zero_q, power_down_flag_n_q, timeout_flag_n_q, file_we_q, osc_halt_q;
  wire  [7:0] flags = {3'h0, timeout_flag_n_q, power_down_flag_n_q, zero_q, digit_carry_flag_q, carry_q};
  int         n_errors, cmp_count;
  cexo_core DUT (.sys_clk, .rst_n, .instr_valid, .instr_op, .literal, .file_addr, .file_data, .dest_sel,
    .watchdog_tick, .wake, .acc_q, .carry_q, .digit_carry_flag_q, .zero_q, .power_down_flag_n_q,
    .timeout_flag_n_q, .file_we_q, .file_waddr_q, .file_wdata_q, .watchdog_counter_q, .prescaler_q, .osc_halt_q);
  // ----
  // Tasks
  // ----
  task check(input [7:0] seen, input [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task run(input [2:0] op, input [7:0] k, input [7:0] f, input d);
    reg [7:0] r;
    reg       c, dc, z, we;
    {r, c, dc, z} = {m_acc, m_c, m_dc, m_z};
    case (op)
      `CEXO_OP_RRF: {r, c} = {m_c, f};
      `CEXO_OP_SUBLIT: {c, dc, r} = {m_acc <= k, m_acc[3:0] <= k[3:0], k - m_acc};
      `CEXO_OP_SUBFILE: {c, dc, r} = {m_acc <= f, m_acc[3:0] <= f[3:0], f - m_acc};
      `CEXO_OP_XORLIT: r = m_acc ^ k;
      `CEXO_OP_XORFILE: r = m_acc ^ f;
      `CEXO_OP_SWAP: r = {f[3:0], f[7:4]};
      default: ;
    endcase
    if (op >= `CEXO_OP_SUBLIT && op <= `CEXO_OP_XORFILE)
      z = r == 8'h00;
    we = d && (op == `CEXO_OP_RRF || op == `CEXO_OP_SUBFILE || op == `CEXO_OP_XORFILE || op == `CEXO_OP_SWAP);
    {instr_op, literal, file_data, dest_sel, instr_valid} = {op, k, f, d, 1'b1};
    file_addr = file_addr + 7'h29;
    @(negedge sys_clk);
    m_acc = we ? m_acc : r;
    {m_c, m_dc, m_z} = {c, dc, z};
    check(acc_q, m_acc);
    check(flags, {3'h0, 1'b1, m_pd, m_z, m_dc, m_c});
    check({7'h0, file_we_q}, {7'h0, we});
    if (we)
      check(file_wdata_q, r);
    if (we)
      check({1'b0, file_waddr_q}, {1'b0, file_addr});
  endtask
  task t_reset;
    check(acc_q, `CEXO_RST_ACC);
    check(flags, {3'h0, `CEXO_RST_STATUS});
    check({7'h0, osc_halt_q}, 8'h00);
  endtask
  task t_lit;
    run(`CEXO_OP_XORLIT, 8'h03, 8'h00, 1'b1);
    run(`CEXO_OP_SUBLIT, 8'h05, 8'h00, 1'b0);
    run(`CEXO_OP_SUBLIT, 8'h02, 8'h00, 1'b0);
    run(`CEXO_OP_XORLIT, 8'h0f, 8'h00, 1'b0);
    run(`CEXO_OP_SUBLIT, 8'h10, 8'h00, 1'b0);
    run(`CEXO_OP_SUBLIT, 8'h00, 8'h00, 1'b0);
    run(`CEXO_OP_SUBLIT, 8'hff, 8'h00, 1'b0);
    run(`CEXO_OP_XORLIT, 8'hff, 8'h00, 1'b0);
  endtask
  task t_file;
    for (int d = 0; d < 2; d++) begin
      run(`CEXO_OP_RRF, 8'h00, 8'h81, d[0]);
      run(`CEXO_OP_RRF, 8'h00, 8'h02, d[0]);
      run(`CEXO_OP_SUBFILE, 8'h00, 8'h40, d[0]);
      run(`CEXO_OP_SUBFILE, 8'h00, m_acc, d[0]);
      run(`CEXO_OP_SUBFILE, 8'h00, 8'h07, d[0]);
      run(`CEXO_OP_XORFILE, 8'h00, 8'h5a, d[0]);
      run(`CEXO_OP_SWAP, 8'h00, 8'h3c, d[0]);
    end
  endtask
  task t_sleep;
    {instr_valid, watchdog_tick} = 2'h1;
    repeat (300) @(negedge sys_clk);
    check(prescaler_q, 8'h2c);
    {instr_valid, instr_op} = {1'b1, `CEXO_OP_SLEEP};
    @(negedge sys_clk);
    {watchdog_tick, instr_op, m_pd} = {1'b0, `CEXO_OP_XORLIT, 1'b0};
    check(watchdog_counter_q, `CEXO_WDOG_CLEAR);
    check(prescaler_q, 8'h00);
    check(flags, {3'h0, 1'b1, m_pd, m_z, m_dc, m_c});
    check({7'h0, osc_halt_q}, 8'h01);
    repeat (3) @(negedge sys_clk);
    check(acc_q, m_acc);
    check({7'h0, file_we_q}, 8'h00);
    {instr_valid, wake} = 2'h1;
    for (int i = 0; i < 8 && osc_halt_q !== 1'b0; i++) @(negedge sys_clk);
    check({7'h0, osc_halt_q}, 8'h00);
    wake = 1'b0;
    @(negedge sys_clk);
    run(`CEXO_OP_XORLIT, 8'h01, 8'h00, 1'b0);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, instr_valid, dest_sel, watchdog_tick, wake, instr_op, literal, file_data, file_addr} = 31'h0;
    {m_acc, m_c, m_dc, m_z, m_pd} = 12'h001;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset;
    t_lit;
    t_file;
    t_sleep;
    summarize;
  end
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule // cexo_core_test
`default_nettype wire
